// ### include/spci_pkg.sv
// Purpose: Shared constants and types for the SDRAM pin command interface
// Assumes: One 50 MHz clock; memory array lives outside this block
// Notes:   Mode register layout follows the usual burst/latency field split
package spci_pkg;
  localparam int ADDR_W     = 13;
  localparam int COL_W      = 10;
  localparam int DATA_W     = 16;
  localparam int BANKS      = 4;
  localparam int AP_BIT     = 10;
  localparam int COL_NARROW = 9;
  localparam int BL_LSB     = 0;
  localparam int BL_W       = 3;
  localparam int BT_BIT     = 3;
  localparam int CL_LSB     = 4;
  localparam int CL_W       = 3;
  localparam int WB_BIT     = 9;
  localparam logic [BL_W-1:0]   BL_FULL    = 3'h7;
  localparam logic [CL_W-1:0]   CL_THREE   = 3'h3;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0_020;
  localparam logic [COL_W:0]    FULL_WIDE  = 11'h2_00;
  localparam logic [COL_W:0]    FULL_NARW  = 11'h4_00;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_MODESET, CMD_STOP
  } spci_cmd_type;

  typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SELF} spci_pwr_type;

  // Command from the strobe levels; a high select masks everything
  function automatic spci_cmd_type spci_decode(input logic selN, input logic rasN,
                                               input logic casN, input logic weN);
    if (selN) begin
      return CMD_DESELECT;
    end
    unique case ({rasN, casN, weN})
      3'b011:  return CMD_ACTIVATE;
      3'b101:  return CMD_READ;
      3'b100:  return CMD_WRITE;
      3'b010:  return CMD_PRECHARGE;
      3'b001:  return CMD_REFRESH;
      3'b000:  return CMD_MODESET;
      3'b110:  return CMD_STOP;
      default: return CMD_NOP;
    endcase
  endfunction : spci_decode
endpackage : spci_pkg

// ### hdl/spci_read_pipe.sv
// Purpose: Read data latency pipe and byte-mask output enables
// Assumes: Beat data arrives in the same cycle as the beat is exposed
// Notes:   Mask acts two edges after sampling, through maskQ and the drive flop
`timescale 1ns/1ps
module spci_read_pipe
  import spci_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              tick,
  input  wire logic              casLatency3,
  input  wire logic              wide,
  input  wire logic              beatValid,
  input  wire logic [DATA_W-1:0] beatData,
  input  wire logic [1:0]        maskIn,
  output logic      [DATA_W-1:0] dataOut,
  output logic      [DATA_W-1:0] dataOeN
);
  logic              stageValid;
  logic [DATA_W-1:0] stageData;
  logic [1:0]        maskQ;
  logic [1:0]        drive;
  logic              srcValid;

  // Extra stage only for latency three
  assign srcValid = casLatency3 ? stageValid : beatValid;
  assign dataOeN  = ~{{(DATA_W/2){drive[1] & wide}}, {(DATA_W/2){drive[0]}}};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stageValid <= 1'b0;
      stageData  <= '0;
    end else if (tick) begin
      stageValid <= beatValid;
      stageData  <= beatData;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      maskQ   <= 2'h3;
      drive   <= 2'h0;
      dataOut <= '0;
    end else if (tick) begin
      maskQ   <= maskIn;
      drive   <= {2{srcValid}} & ~maskQ;
      dataOut <= casLatency3 ? stageData : beatData;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_READ_MASK_LATENCY: assert property (tick && maskIn[0] ##1 tick |=> dataOeN[0])
    else $error("Low byte driven despite mask two cycles earlier");
  AST_READ_DRIVE_AFTER_CL2: assert property (
    tick && !casLatency3 && !maskIn[0] ##1 tick && !casLatency3 && beatValid
    |=> !dataOeN[0])
    else $error("Unmasked read beat not driven");
  COV_MASKED_READ: cover property (tick && srcValid && maskQ[0]);
endmodule : spci_read_pipe

// ### hdl/spci_command_core.sv
// Purpose: Device-side command decode, bank state, bursts and data path of an SDRAM
// Assumes: Array storage is external; it answers coreColumn reads within one cycle
// Notes:   Clock gate freezes bank, mode and burst state; coreWrite, coreByteEn and coreWriteData still load; the pins are otherwise plain synchronous inputs
// Notes on behaviour
// - All inputs are taken only at the rising clock edge.
// - Clock gate low freezes state and enters power-down or self-refresh.
// - Low select enables the command decoder; high select disables it.
// - Deselected cycles ignore new commands but running bursts continue.
// - Row, column and write strobes together choose the command.
// - Activate stores the thirteen-bit address as the bank's row.
// - Column uses ten low bits for by-8, nine for by-16.
// - Address bit 10 high on read or write closes the bank after burst.
// - Precharge closes all banks with bit 10 high, else the selected one.
// - Two bank-select inputs pick one of four banks.
// - Sampled mask high puts the matching data buffers in high impedance.
// - Read mask acts as output enable two cycles later.
// - Write mask blocks the data sampled in the same cycle.
// - All three strobes low loads the mode register from the address.
// - Activate opens the word line of the selected bank.
// - Write strobe high in a column command reads, low writes.
`timescale 1ns/1ps
module spci_command_core
  import spci_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              wide,
  input  wire logic              clockGate,
  input  wire logic              selectN,
  input  wire logic              rowStrobeN,
  input  wire logic              colStrobeN,
  input  wire logic              writeStrobeN,
  input  wire logic [ADDR_W-1:0] addressBus,
  input  wire logic              arraySelectLo,
  input  wire logic              arraySelectHi,
  input  wire logic              lowByteMask,
  input  wire logic              highByteMask,
  input  wire logic [DATA_W-1:0] dataLinesIn,
  output logic      [DATA_W-1:0] dataLinesOut,
  output logic      [DATA_W-1:0] dataLinesOeN,
  input  wire logic [DATA_W-1:0] coreReadData,
  output logic                   coreRead,
  output logic      [1:0]        coreBank,
  output logic      [ADDR_W-1:0] coreRow,
  output logic      [COL_W-1:0]  coreColumn,
  output logic                   coreWrite,
  output logic      [1:0]        coreByteEn,
  output logic      [1:0]        coreWriteBank,
  output logic      [ADDR_W-1:0] coreWriteRow,
  output logic      [COL_W-1:0]  coreWriteColumn,
  output logic      [DATA_W-1:0] coreWriteData,
  output logic                   refreshPulse,
  output logic      [BANKS-1:0]  bankOpen,
  output logic      [ADDR_W-1:0] modeReg,
  output logic                   powerDown,
  output logic                   selfRefresh
);
  logic              tick;
  spci_cmd_type      cmd;
  spci_pwr_type      pwrState;
  logic [1:0]        bankSel;
  logic [1:0]        maskVec;
  logic [COL_W-1:0]  cmdColumn;
  logic [ADDR_W-1:0] rowIndex [BANKS];
  logic              burstActive;
  logic              burstRead;
  logic              burstAuto;
  logic [1:0]        burstBank;
  logic [COL_W-1:0]  burstStart;
  logic [COL_W:0]    burstCount;
  logic [COL_W:0]    beats;
  logic [COL_W:0]    writeBeats;
  logic              colCmd;
  logic              lastBeat;
  logic              autoCloseNow;

  // Beat count from the burst length field
  function automatic logic [COL_W:0] burst_beats(input logic [BL_W-1:0] code,
                                                 input logic isWide);
    if (code == BL_FULL) begin
      return isWide ? FULL_WIDE : FULL_NARW;
    end
    return (COL_W+1)'(1) << code[1:0];
  endfunction : burst_beats

  // Column of one beat, wrapping inside the burst boundary
  function automatic logic [COL_W-1:0] beat_column(input logic [COL_W-1:0] start,
                                                   input logic [COL_W:0]   idx,
                                                   input logic [COL_W:0]   len,
                                                   input logic             leave);
    logic [COL_W-1:0] span;
    logic [COL_W-1:0] step;
    span = len[COL_W-1:0] - 1'b1;
    step = leave ? (start ^ idx[COL_W-1:0]) : (start + idx[COL_W-1:0]);
    if (len[COL_W]) begin
      return step;
    end
    return (start & ~span) | (step & span);
  endfunction : beat_column

  assign tick       = (pwrState == PWR_RUN);
  assign cmd        = spci_decode(selectN, rowStrobeN, colStrobeN, writeStrobeN);
  assign bankSel    = {arraySelectHi, arraySelectLo};
  assign maskVec    = wide ? {highByteMask, lowByteMask} : {1'b0, lowByteMask};
  assign cmdColumn  = wide ? {1'b0, addressBus[COL_NARROW-1:0]} : addressBus[COL_W-1:0];
  assign beats      = burst_beats(modeReg[BL_LSB +: BL_W], wide);
  assign writeBeats = modeReg[WB_BIT] ? (COL_W+1)'(1) : beats;
  assign colCmd     = tick && (cmd == CMD_READ || cmd == CMD_WRITE) && bankOpen[bankSel];
  assign lastBeat   = (burstCount + 1'b1) == (burstRead ? beats : writeBeats);
  assign autoCloseNow = tick && burstActive && burstAuto && lastBeat && !colCmd;
  assign coreRead   = tick && burstActive && burstRead;
  assign coreBank   = burstBank;
  assign coreRow    = rowIndex[burstBank];
  assign coreColumn = beat_column(burstStart, burstCount, beats, modeReg[BT_BIT]);
  assign powerDown  = (pwrState == PWR_DOWN);
  assign selfRefresh = (pwrState == PWR_SELF);

  // Power-down is left with the gate high; commands are only taken in run state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pwrState <= PWR_RUN;
    end else if (tick && !clockGate) begin
      pwrState <= (cmd == CMD_REFRESH) ? PWR_SELF : PWR_DOWN;
    end else if (!tick && clockGate) begin
      pwrState <= PWR_RUN;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      modeReg <= MODE_RESET;
    end else if (tick && cmd == CMD_MODESET) begin
      modeReg <= addressBus;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      refreshPulse <= 1'b0;
    end else begin
      refreshPulse <= tick && clockGate && cmd == CMD_REFRESH;
    end
  end

  // Bank open/close; a new column command on the same edge takes over the bank
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bankOpen <= '0;
      for (int i = 0; i < BANKS; i++) begin
        rowIndex[i] <= '0;
      end
    end else if (tick) begin
      if (autoCloseNow) begin
        bankOpen[burstBank] <= 1'b0;
      end
      unique case (cmd)
        CMD_ACTIVATE: begin
          bankOpen[bankSel] <= 1'b1;
          rowIndex[bankSel] <= addressBus;
        end
        CMD_PRECHARGE: begin
          if (addressBus[AP_BIT]) begin
            bankOpen <= '0;
          end else begin
            bankOpen[bankSel] <= 1'b0;
          end
        end
        CMD_WRITE: begin
          if (colCmd && addressBus[AP_BIT] && writeBeats == (COL_W+1)'(1)) begin
            bankOpen[bankSel] <= 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Burst sequencing keeps running while deselected
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      burstActive <= 1'b0;
      burstRead   <= 1'b0;
      burstAuto   <= 1'b0;
      burstBank   <= '0;
      burstStart  <= '0;
      burstCount  <= '0;
    end else if (tick) begin
      if (colCmd) begin
        burstRead   <= (cmd == CMD_READ);
        burstAuto   <= addressBus[AP_BIT];
        burstBank   <= bankSel;
        burstStart  <= cmdColumn;
        burstCount  <= (cmd == CMD_READ) ? '0 : (COL_W+1)'(1);
        burstActive <= (cmd == CMD_READ) || writeBeats != (COL_W+1)'(1);
      end else if (cmd == CMD_STOP || cmd == CMD_PRECHARGE) begin
        burstActive <= 1'b0;
      end else if (burstActive) begin
        burstCount <= burstCount + 1'b1;
        if (lastBeat) begin
          burstActive <= 1'b0;
        end
      end
    end
  end

  // Write beats, registered toward the array with the mask as byte enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coreWrite       <= 1'b0;
      coreByteEn      <= '0;
      coreWriteBank   <= '0;
      coreWriteRow    <= '0;
      coreWriteColumn <= '0;
      coreWriteData   <= '0;
    end else begin
      coreWrite  <= 1'b0;
      coreByteEn <= ~maskVec & {wide, 1'b1};
      coreWriteData <= dataLinesIn;
      if (tick && colCmd && cmd == CMD_WRITE) begin
        coreWrite       <= 1'b1;
        coreWriteBank   <= bankSel;
        coreWriteRow    <= rowIndex[bankSel];
        coreWriteColumn <= cmdColumn;
      end else if (tick && burstActive && !burstRead && !colCmd
                   && cmd != CMD_STOP && cmd != CMD_PRECHARGE) begin
        coreWrite       <= 1'b1;
        coreWriteBank   <= burstBank;
        coreWriteRow    <= rowIndex[burstBank];
        coreWriteColumn <= coreColumn;
      end
    end
  end

  spci_read_pipe u_read_pipe (
    .clock       (clock),
    .arst_n      (arst_n),
    .tick        (tick),
    .casLatency3 (modeReg[CL_LSB +: CL_W] == CL_THREE),
    .wide        (wide),
    .beatValid   (coreRead),
    .beatData    (coreReadData),
    .maskIn      (maskVec),
    .dataOut     (dataLinesOut),
    .dataOeN     (dataLinesOeN)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  AST_DESELECT_KEEPS_MODE: assert property (tick && selectN |=> $stable(modeReg))
    else $error("Mode changed while deselected");
  AST_DESELECT_BURST_RUNS: assert property (
    tick && selectN && burstActive && !lastBeat |=> burstActive)
    else $error("Burst stopped by deselect");
  AST_MODE_SET: assert property (tick && cmd == CMD_MODESET |=> modeReg == $past(addressBus))
    else $error("Mode register not loaded");
  AST_ACTIVATE_ROW: assert property (tick && cmd == CMD_ACTIVATE
    |=> bankOpen[$past(bankSel)] && rowIndex[$past(bankSel)] == $past(addressBus))
    else $error("Row not captured on activate");
  AST_PRECHARGE_ALL: assert property (
    tick && cmd == CMD_PRECHARGE && addressBus[AP_BIT] |=> bankOpen == '0)
    else $error("Precharge all left a bank open");
  AST_AUTO_CLOSE: assert property (autoCloseNow && cmd != CMD_ACTIVATE
    |=> !bankOpen[$past(burstBank)])
    else $error("Auto precharge did not close bank");
  AST_READ_DIRECTION: assert property (colCmd && cmd == CMD_READ
    |=> burstActive && burstRead && coreColumn == $past(cmdColumn))
    else $error("Read burst not started at column");
  AST_WRITE_MASK: assert property (colCmd && cmd == CMD_WRITE
    |=> coreWrite && coreByteEn == (~$past(maskVec) & {$past(wide), 1'b1}))
    else $error("Write beat mask wrong");
  AST_POWER_ENTRY: assert property (tick && !clockGate
    |=> ($past(cmd) == CMD_REFRESH ? selfRefresh : powerDown))
    else $error("Gate low did not suspend clocking");
  AST_FROZEN: assert property (!tick && !clockGate |=> $stable(bankOpen))
    else $error("Bank state moved while clock gated");
  COV_READ_BURST: cover property (colCmd && cmd == CMD_READ ##1 burstActive [*3]);
  COV_WRITE_BURST: cover property (colCmd && cmd == CMD_WRITE ##1 coreWrite ##1 coreWrite);
  COV_SELF_REFRESH: cover property (tick && !clockGate && cmd == CMD_REFRESH ##1 selfRefresh);
endmodule : spci_command_core

// ### tb/spci_ctrl_model.sv
// Purpose: Memory controller model driving the SDRAM command pins
// Assumes: Pins change at the falling edge and are sampled at the rising one
// Notes:   Idle edges deselect with inverted strobes, so leaky decode shows up
`timescale 1ns/1ps
module spci_ctrl_model
  import spci_pkg::*;
(
  input  wire logic              clock,
  output logic                   clockGate,
  output logic                   selectN,
  output logic                   rowStrobeN,
  output logic                   colStrobeN,
  output logic                   writeStrobeN,
  output logic      [ADDR_W-1:0] addressBus,
  output logic      [1:0]        bank,
  output logic      [1:0]        mask,
  output logic      [DATA_W-1:0] dataOut
);
  logic gateWant;

  initial begin
    gateWant = 1'b1;
    clockGate = 1'b1;
    selectN = 1'b1;
    {rowStrobeN, colStrobeN, writeStrobeN} = 3'h7;
    addressBus = '0;
    bank = 2'h0;
    mask = 2'h0;
    dataOut = '0;
  end

  // One command edge, then one deselected edge
  task automatic issue(input logic s, input logic [2:0] rcw, input logic [1:0] b,
                       input logic [ADDR_W-1:0] a, input logic [1:0] m = 2'h0,
                       input logic [DATA_W-1:0] d = 16'h0000);
    @(negedge clock);
    clockGate = gateWant; // Only changed between bursts
    selectN = s;
    {rowStrobeN, colStrobeN, writeStrobeN} = rcw;
    bank = b;
    addressBus = a;
    mask = m;
    dataOut = d;
    @(negedge clock);
    selectN = 1'b1;
    {rowStrobeN, colStrobeN, writeStrobeN} = ~rcw;
    addressBus = ~a;
    mask = 2'h0;
    dataOut = ~d;
  endtask : issue
endmodule : spci_ctrl_model

// ### tb/spci_command_core_bench.sv
// Purpose: Self-checking bench for the SDRAM pin command interface
// Assumes: Array data is a fixed pattern of the column; CL2 until the last by-8 reads
// Notes:   A second reset switches to by-8 so both organizations are seen
`timescale 1ns/1ps
module spci_command_core_bench
  import spci_pkg::*;
;
  logic              clock;
  logic              arst_n;
  logic              wide;
  logic              clockGate, selectN, rowStrobeN, colStrobeN, writeStrobeN;
  logic [ADDR_W-1:0] addressBus, coreRow, coreWriteRow, modeReg;
  logic [1:0]        bank, mask, coreBank, coreByteEn, coreWriteBank;
  logic [DATA_W-1:0] dataLinesIn, dataLinesOut, dataLinesOeN, coreReadData, coreWriteData;
  logic [COL_W-1:0]  coreColumn, coreWriteColumn;
  logic              coreRead, coreWrite, refreshPulse, powerDown, selfRefresh;
  logic [BANKS-1:0]  bankOpen;
  int                miscompares;
  int                cmp_count;

  // Array stand-in: answers any read beat at once with a column pattern
  assign coreReadData = {6'h2a, coreColumn};

  spci_ctrl_model pm (.clock(clock), .clockGate(clockGate), .selectN(selectN),
    .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN), .writeStrobeN(writeStrobeN),
    .addressBus(addressBus), .bank(bank), .mask(mask), .dataOut(dataLinesIn));

  spci_command_core DUT (.clock(clock), .arst_n(arst_n), .wide(wide),
    .clockGate(clockGate), .selectN(selectN), .rowStrobeN(rowStrobeN),
    .colStrobeN(colStrobeN), .writeStrobeN(writeStrobeN), .addressBus(addressBus),
    .arraySelectLo(bank[0]), .arraySelectHi(bank[1]), .lowByteMask(mask[0]),
    .highByteMask(mask[1]), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
    .dataLinesOeN(dataLinesOeN), .coreReadData(coreReadData), .coreRead(coreRead),
    .coreBank(coreBank), .coreRow(coreRow), .coreColumn(coreColumn),
    .coreWrite(coreWrite), .coreByteEn(coreByteEn), .coreWriteBank(coreWriteBank),
    .coreWriteRow(coreWriteRow), .coreWriteColumn(coreWriteColumn),
    .coreWriteData(coreWriteData), .refreshPulse(refreshPulse), .bankOpen(bankOpen),
    .modeReg(modeReg), .powerDown(powerDown), .selfRefresh(selfRefresh));

  always #10 clock = ~clock;

  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // About 70 cycles are needed; a hang costs at most 5000
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    clock = 1'b0;
    arst_n = 1'b0;
    wide = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    chk(dataLinesOeN, 16'hffff, "idle drive");
    pm.issue(1'b0, 3'h0, 2'h0, 13'h0_021);
    chk(modeReg, 13'h0_021, "mode set");
    pm.issue(1'b0, 3'h3, 2'h2, 13'h1_abc);
    chk(bankOpen, 4'h4, "activate");
    pm.issue(1'b1, 3'h3, 2'h1, 13'h0_000);
    chk(bankOpen, 4'h4, "deselected");
    pm.issue(1'b0, 3'h5, 2'h2, 13'h0_205);
    chk(coreRead, 1'b1, "read beat");
    chk(coreRow, 13'h1_abc, "row");
    chk(coreBank, 2'h2, "bank");
    chk(coreColumn, 10'h005, "column x16");
    @(negedge clock);
    chk(dataLinesOut, 16'ha805, "beat 0");
    chk(dataLinesOeN, 16'h0000, "beat 0 drive");
    @(negedge clock);
    chk(dataLinesOut, 16'ha804, "beat 1 deselected");
    @(negedge clock);
    chk(dataLinesOeN, 16'hffff, "after burst");
    chk(bankOpen, 4'h4, "no auto close");
    pm.issue(1'b0, 3'h5, 2'h2, 13'h0_408, 2'h1);
    @(negedge clock);
    chk(dataLinesOeN, 16'h00ff, "low byte masked");
    @(negedge clock);
    chk(dataLinesOeN, 16'h0000, "mask released");
    chk(dataLinesOut, 16'ha809, "beat 1 data");
    chk(bankOpen, 4'h0, "auto close");
    pm.issue(1'b0, 3'h3, 2'h1, 13'h0_003);
    pm.issue(1'b0, 3'h4, 2'h1, 13'h0_007, 2'h2, 16'h1234);
    chk(coreWrite, 1'b1, "write 0");
    chk(coreByteEn, 2'h1, "high masked");
    chk(coreWriteData, 16'h1234, "write data");
    chk(coreWriteColumn, 10'h007, "write col");
    chk(coreWriteRow, 13'h0_003, "write row");
    chk(coreWriteBank, 2'h1, "write bank");
    @(negedge clock);
    chk(coreByteEn, 2'h3, "beat 1 unmasked");
    chk(coreWriteData, 16'hedcb, "beat 1 data");
    @(negedge clock);
    chk(coreWrite, 1'b0, "write done");
    pm.issue(1'b0, 3'h3, 2'h0, 13'h0_000);
    pm.issue(1'b0, 3'h2, 2'h3, 13'h0_000);
    chk(bankOpen, 4'h3, "close idle bank");
    pm.issue(1'b0, 3'h2, 2'h0, 13'h0_000);
    chk(bankOpen, 4'h2, "close bank 0");
    pm.issue(1'b0, 3'h2, 2'h0, 13'h0_400);
    chk(bankOpen, 4'h0, "close all");
    pm.issue(1'b0, 3'h1, 2'h0, 13'h0_000);
    chk(refreshPulse, 1'b1, "refresh");
    pm.gateWant = 1'b0;
    pm.issue(1'b0, 3'h1, 2'h0, 13'h0_000);
    chk(selfRefresh, 1'b1, "self refresh");
    pm.gateWant = 1'b1;
    pm.issue(1'b1, 3'h7, 2'h0, 13'h0_000);
    chk(selfRefresh, 1'b0, "self refresh exit");
    pm.gateWant = 1'b0;
    pm.issue(1'b1, 3'h7, 2'h0, 13'h0_000);
    chk(powerDown, 1'b1, "power down");
    pm.issue(1'b0, 3'h3, 2'h3, 13'h0_000);
    chk(bankOpen, 4'h0, "frozen");
    pm.gateWant = 1'b1;
    pm.issue(1'b1, 3'h7, 2'h0, 13'h0_000);
    chk(powerDown, 1'b0, "wake");
    arst_n = 1'b0;
    wide = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    chk(modeReg, 13'h0_020, "mode after reset");
    pm.issue(1'b0, 3'h3, 2'h0, 13'h0_000);
    pm.issue(1'b0, 3'h5, 2'h0, 13'h0_3ff);
    chk(coreColumn, 10'h3ff, "column x8");
    @(negedge clock);
    chk(dataLinesOeN, 16'hff00, "x8 drive");
    chk(dataLinesOut[7:0], 8'hff, "x8 data");
    pm.issue(1'b0, 3'h0, 2'h0, 13'h0_03a);
    chk(modeReg, 13'h0_03a, "mode CL3 interleave");
    pm.issue(1'b0, 3'h5, 2'h0, 13'h0_001);
    @(negedge clock);
    chk(dataLinesOeN, 16'hffff, "CL3 not early");
    @(negedge clock);
    chk(dataLinesOeN, 16'hff00, "CL3 beat 0 drive");
    chk(dataLinesOut[7:0], 8'h01, "CL3 beat 0");
    @(negedge clock);
    chk(dataLinesOut[7:0], 8'h00, "interleave beat 1");
    pm.issue(1'b0, 3'h5, 2'h0, 13'h0_001);
    pm.issue(1'b0, 3'h6, 2'h0, 13'h0_000);
    chk(coreRead, 1'b0, "stop ends burst");
    pm.issue(1'b0, 3'h0, 2'h0, 13'h0_23a);
    pm.issue(1'b0, 3'h4, 2'h0, 13'h0_405, 2'h0, 16'h005a);
    chk(coreWrite, 1'b1, "single write");
    chk(bankOpen, 4'h0, "single write auto close");
    @(negedge clock);
    chk(coreWrite, 1'b0, "single beat only");
    tally_and_finish;
  end
endmodule : spci_command_core_bench
